// *** rtl/ddc_defs.svh ***
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
// Operation
// - write starts with start, address, write bit
// - command, MSB, LSB bytes each acked, stop
// - readback sends address, then control byte
// - repeated start, read address, two bytes
// - both channels selected reads channel A
// - A pair, four filler bytes, B pair
// - after B wrap to A until NACK
// - command 0100 loads power-down fields
// - field codes normal, 1k, 100k, tristate
// - power-down keeps DAC register unchanged
// - input then DAC stage, strobe transfers
// - strobe low: write 0001 updates both
// - strobe high: input only, fall loads
// - command 0101 loads mask, ignores address
// - mask bit zero lets strobe act
// - mask bit one sees strobe high
// - 24-bit word, command, address, code, MSB first
// - 0001 input, 0010 copy, 0011 both, 0000 none
// - address bit 3 B, bit 0 A
// - bus address 00011 plus two straps
`define DDC_ADDR_FIXED 5'h03
`define DDC_CMD_WR_IN  4'h1
`define DDC_CMD_UPD    4'h2
`define DDC_CMD_WR_UPD 4'h3
`define DDC_CMD_PWR    4'h4
`define DDC_CMD_MASK   4'h5
`define DDC_ADDR_BIT_A 0
`define DDC_ADDR_BIT_B 3
`define DDC_PD_LSB_A   0
`define DDC_PD_LSB_B   6
`define DDC_BYTE_ADDR  3'h0
`define DDC_BYTE_CMD   3'h1
`define DDC_BYTE_MSB   3'h2
`define DDC_BYTE_LSB   3'h3
`define DDC_BYTE_OVER  3'h4
`define DDC_RB_A_HI    3'h0
`define DDC_RB_A_LO    3'h1
`define DDC_RB_B_HI    3'h6
`define DDC_RB_B_LO    3'h7
`define DDC_FILLER     8'h00
`define DDC_IDLE_BYTE  8'hFF
`define DDC_SYNC_RESET 5'h13
`endif

// *** rtl/ddc_pkg.sv ***
package ddc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RX    = 3'b001,
        ST_RXEND = 3'b010,
        ST_ACK   = 3'b011,
        ST_TX    = 3'b100,
        ST_MACK  = 3'b101
    } ddc_state_t;
    typedef logic [11:0] ddc_code_t;
    typedef logic [1:0]  ddc_pd_t;
endpackage

// *** rtl/ddc_fifo_if.sv ***
interface ddc_fifo_if #(parameter int WIDTH = 8) ();
    logic             wrValid;
    logic             wrReady;
    logic [WIDTH-1:0] wrData;
    logic             rdValid;
    logic             rdReady;
    logic [WIDTH-1:0] rdData;
    logic             flush;
    modport store (input wrValid, wrData, rdReady, flush, output wrReady, rdValid, rdData);
    modport user  (output wrValid, wrData, rdReady, flush, input wrReady, rdValid, rdData);
endinterface

// *** rtl/ddc_sync.sv ***
module ddc_sync #(
    parameter int               WIDTH     = 5,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  logic             core_clk,
    input  logic             resetn,
    input  logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    ////////////////////////////////////////////////////////////////
    // two flops per bit; stage one feeds only stage two
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic meta_r;
        always_ff @(posedge core_clk)
        begin
            if (!resetn)
            begin
                meta_r     <= RESET_VAL[i];
                syncOut[i] <= RESET_VAL[i];
            end
            else
            begin
                meta_r     <= asyncIn[i];
                syncOut[i] <= meta_r;
            end
        end
    end
endmodule // ddc_sync

// *** rtl/ddc_fifo.sv ***
module ddc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input logic       core_clk,
    input logic       resetn,
    ddc_fifo_if.store bus
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_r;
    logic [AW:0]      rdPtr_r;
    logic             full;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////
    // extra pointer bit tells full from empty
    assign full        = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    assign bus.rdValid = (wrPtr_r != rdPtr_r);
    assign bus.wrReady = !full;
    assign push        = bus.wrValid && !full;
    assign pop         = bus.rdReady && bus.rdValid;
    assign bus.rdData  = mem[rdPtr_r[AW-1:0]];

    // storage written only on accepted push
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wrPtr_r[AW-1:0]] <= bus.wrData;
    end

    // pointers; flush empties at once
    always_ff @(posedge core_clk)
    begin
        if (!resetn || bus.flush)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end
        else
        begin
            if (push)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (pop)
                rdPtr_r <= rdPtr_r + 1'b1;
        end
    end

    // pointer that just made it full moved last cycle, so look one cycle on
    AST_FIFO_FULL_STALLS: assert property (@(posedge core_clk) disable iff (!resetn)
        (full && !bus.flush) |-> !bus.wrReady ##1 $stable(wrPtr_r))
        else $error("fifo accepted data while full");
endmodule // ddc_fifo

// *** rtl/ddc_top.sv ***
`include "ddc_defs.svh"

module ddc_top (
    input  logic              core_clk,
    input  logic              resetn,
    input  logic              sclIn,
    input  logic              sdaIn,
    output logic              sdaOut,
    output logic              sdaOe,
    input  logic              busAddrStrapLo,
    input  logic              busAddrStrapHi,
    input  logic              loadStrobeN,
    output ddc_pkg::ddc_code_t chaDacCode,
    output ddc_pkg::ddc_code_t chbDacCode,
    output logic              chaPdModeHi,
    output logic              chaPdModeLo,
    output logic              chbPdModeHi,
    output logic              chbPdModeLo
);
    import ddc_pkg::*;

    logic [4:0] pinS;
    logic       sclS;
    logic       sdaS;
    logic       strapLoS;
    logic       strapHiS;
    logic       strobeS;
    logic       sclPrev_r;
    logic       sdaPrev_r;
    logic       strobePrev_r;
    logic       strapLo_r;
    logic       strapHi_r;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic       strobeFall;
    ddc_state_t state_r;
    logic [2:0] bitCnt_r;
    logic [2:0] byteIdx_r;
    logic [7:0] shift_r;
    logic       rxDone_r;
    logic       rxTake;
    logic       ackEn_r;
    logic       readMode_r;
    logic       addrHit;
    logic [6:0] ownAddr;
    logic [7:0] txShift_r;
    logic       txLoad;
    logic       sdaOe_r;
    logic [7:0] cmdByte_r;
    logic [7:0] msbByte_r;
    logic [3:0] cmdCode;
    ddc_code_t  dataCode;
    logic       execPulse;
    logic [3:0] mask_r;
    logic [2:0] rbIdx_r;
    logic [7:0] rbByte;
    logic       genActive_r;
    ddc_code_t  inReg [2];
    ddc_code_t  dacReg [2];
    ddc_pd_t    pdMode [2];

    ddc_fifo_if #(.WIDTH(8)) fifoBus ();

    ////////////////////////////////////////////////////////////////
    // pins cross into core_clk before any logic looks at them
    ddc_sync #(
        .WIDTH     (5),
        .RESET_VAL (`DDC_SYNC_RESET)
    ) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .asyncIn  ({loadStrobeN, busAddrStrapHi, busAddrStrapLo, sdaIn, sclIn}),
        .syncOut  (pinS)
    );

    assign sclS     = pinS[0];
    assign sdaS     = pinS[1];
    assign strapLoS = pinS[2];
    assign strapHiS = pinS[3];
    assign strobeS  = pinS[4];

    // previous samples for edge detection
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            sclPrev_r    <= 1'b1;
            sdaPrev_r    <= 1'b1;
            strobePrev_r <= 1'b1;
        end
        else
        begin
            sclPrev_r    <= sclS;
            sdaPrev_r    <= sdaS;
            strobePrev_r <= strobeS;
        end
    end

    // straps caught after reset release, never by the reset itself
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            strapLo_r <= 1'b0;
            strapHi_r <= 1'b0;
        end
        else
        begin
            strapLo_r <= strapLoS;
            strapHi_r <= strapHiS;
        end
    end

    // bus events; sda moves only while scl low, so no false start
    assign sclRise    = sclS && !sclPrev_r;
    assign sclFall    = !sclS && sclPrev_r;
    assign startCond  = sclS && sclPrev_r && sdaPrev_r && !sdaS;
    assign stopCond   = sclS && sclPrev_r && !sdaPrev_r && sdaS;
    assign strobeFall = strobePrev_r && !strobeS;
    assign ownAddr    = {`DDC_ADDR_FIXED, strapHi_r, strapLo_r};
    assign addrHit    = (shift_r[7:1] == ownAddr);
    assign rxTake     = rxDone_r && (state_r == ST_RX) && !startCond && !stopCond;

    ////////////////////////////////////////////////////////////////
    // byte framing state machine
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_r    <= ST_IDLE;
            bitCnt_r   <= 3'h0;
            byteIdx_r  <= `DDC_BYTE_ADDR;
            rxDone_r   <= 1'b0;
            ackEn_r    <= 1'b0;
            readMode_r <= 1'b0;
        end
        else if (startCond)
        begin
            state_r    <= ST_RX;
            bitCnt_r   <= 3'h0;
            byteIdx_r  <= `DDC_BYTE_ADDR;
            rxDone_r   <= 1'b0;
            ackEn_r    <= 1'b0;
            readMode_r <= 1'b0;
        end
        else if (stopCond)
        begin
            state_r  <= ST_IDLE;
            rxDone_r <= 1'b0;
        end
        else
        begin
            rxDone_r <= (state_r == ST_RX) && sclRise && (bitCnt_r == 3'h7);
            case (state_r)
                ST_RX:
                begin
                    if (sclRise)
                        bitCnt_r <= bitCnt_r + 3'h1;
                    if (rxDone_r)
                    begin
                        state_r <= ST_RXEND;
                        if (byteIdx_r == `DDC_BYTE_ADDR)
                        begin
                            ackEn_r    <= addrHit;
                            readMode_r <= shift_r[0];
                        end
                        else
                            ackEn_r <= (byteIdx_r != `DDC_BYTE_OVER);
                    end
                end
                ST_RXEND:
                begin
                    // a byte we refuse ends our part in the transfer
                    if (sclFall)
                        state_r <= ackEn_r ? ST_ACK : ST_IDLE;
                end
                ST_ACK:
                begin
                    if (sclFall)
                    begin
                        state_r  <= readMode_r ? ST_TX : ST_RX;
                        bitCnt_r <= 3'h0;
                        if (!readMode_r && byteIdx_r != `DDC_BYTE_OVER)
                            byteIdx_r <= byteIdx_r + 3'h1;
                    end
                end
                ST_TX:
                begin
                    if (sclFall)
                    begin
                        if (bitCnt_r == 3'h7)
                            state_r <= ST_MACK;
                        bitCnt_r <= bitCnt_r + 3'h1;
                    end
                end
                ST_MACK:
                begin
                    // master nack means no more bytes
                    if (sclRise && sdaS)
                        state_r <= ST_IDLE;
                    else if (sclFall)
                        state_r <= ST_TX;
                end
                ST_IDLE:
                begin
                    bitCnt_r <= 3'h0;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // serial in, msb first
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            shift_r <= 8'h00;
        else if (state_r == ST_RX && sclRise)
            shift_r <= {shift_r[6:0], sdaS};
    end

    ////////////////////////////////////////////////////////////////
    // serial out: byte taken from the fifo at each byte start
    assign txLoad            = sclFall && ((state_r == ST_ACK && readMode_r) || state_r == ST_MACK);
    assign fifoBus.rdReady   = txLoad;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            txShift_r <= `DDC_IDLE_BYTE;
        else if (txLoad)
            txShift_r <= fifoBus.rdValid ? fifoBus.rdData : `DDC_IDLE_BYTE;
        else if (state_r == ST_TX && sclFall)
            txShift_r <= {txShift_r[6:0], 1'b1};
    end

    // open drain: only ever pull low; registered to keep it glitch free
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            sdaOe_r <= 1'b0;
        else
            sdaOe_r <= (state_r == ST_ACK && ackEn_r) || (state_r == ST_TX && !txShift_r[7]);
    end

    assign sdaOe  = sdaOe_r;
    assign sdaOut = 1'b0;

    ////////////////////////////////////////////////////////////////
    // write bytes collected; nothing but the readback start channel acts before the third data byte
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            cmdByte_r <= 8'h00;
            msbByte_r <= 8'h00;
        end
        else if (rxTake && !readMode_r)
        begin
            if (byteIdx_r == `DDC_BYTE_CMD)
                cmdByte_r <= shift_r;
            if (byteIdx_r == `DDC_BYTE_MSB)
                msbByte_r <= shift_r;
        end
    end

    assign cmdCode   = cmdByte_r[7:4];
    assign dataCode  = {msbByte_r, shift_r[7:4]};
    assign execPulse = rxTake && !readMode_r && (byteIdx_r == `DDC_BYTE_LSB);

    // mask register, address bits of this command ignored
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            mask_r <= 4'h0;
        else if (execPulse && cmdCode == `DDC_CMD_MASK)
            mask_r <= shift_r[3:0];
    end

    ////////////////////////////////////////////////////////////////
    // per channel double buffer and power-down field
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        localparam int ABIT = (ch == 0) ? `DDC_ADDR_BIT_A : `DDC_ADDR_BIT_B;
        localparam int PLSB = (ch == 0) ? `DDC_PD_LSB_A : `DDC_PD_LSB_B;
        logic sel;
        logic masked;
        logic lowEff;

        assign sel    = cmdByte_r[ABIT];
        assign masked = mask_r[ABIT];
        assign lowEff = !strobeS && !masked;

        // input stage
        always_ff @(posedge core_clk)
        begin
            if (!resetn)
                inReg[ch] <= 12'h000;
            else if (execPulse && sel && (cmdCode == `DDC_CMD_WR_IN || cmdCode == `DDC_CMD_WR_UPD))
                inReg[ch] <= dataCode;
        end

        // dac stage; same-cycle write beats the strobe copy
        always_ff @(posedge core_clk)
        begin
            if (!resetn)
                dacReg[ch] <= 12'h000;
            else if (execPulse && sel && cmdCode == `DDC_CMD_WR_UPD)
                dacReg[ch] <= dataCode;
            else if (execPulse && sel && cmdCode == `DDC_CMD_WR_IN && lowEff)
                dacReg[ch] <= dataCode;
            else if (execPulse && sel && cmdCode == `DDC_CMD_UPD)
                dacReg[ch] <= inReg[ch];
            else if (strobeFall && !masked)
                dacReg[ch] <= inReg[ch];
        end

        // power-down field; dac stage untouched by it
        always_ff @(posedge core_clk)
        begin
            if (!resetn)
                pdMode[ch] <= 2'h0;
            else if (execPulse && cmdCode == `DDC_CMD_PWR)
                pdMode[ch] <= shift_r[PLSB +: 2];
        end
    end

    assign chaDacCode  = dacReg[0];
    assign chbDacCode  = dacReg[1];
    assign chaPdModeHi = pdMode[0][1];
    assign chaPdModeLo = pdMode[0][0];
    assign chbPdModeHi = pdMode[1][1];
    assign chbPdModeLo = pdMode[1][0];

    ////////////////////////////////////////////////////////////////
    // readback prefetch; pointer ends up ahead by what was prefetched
    always_comb
    begin
        case (rbIdx_r)
            `DDC_RB_A_HI: rbByte = inReg[0][11:4];
            `DDC_RB_A_LO: rbByte = {inReg[0][3:0], 4'h0};
            `DDC_RB_B_HI: rbByte = inReg[1][11:4];
            `DDC_RB_B_LO: rbByte = {inReg[1][3:0], 4'h0};
            default:      rbByte = `DDC_FILLER;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn || startCond || stopCond)
            genActive_r <= 1'b0;
        else if (rxTake && byteIdx_r == `DDC_BYTE_ADDR && addrHit && shift_r[0])
            genActive_r <= 1'b1;
    end

    // control byte picks start channel; A when both chosen
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            rbIdx_r <= `DDC_RB_A_HI;
        else if (rxTake && !readMode_r && byteIdx_r == `DDC_BYTE_CMD)
            rbIdx_r <= (shift_r[`DDC_ADDR_BIT_B] && !shift_r[`DDC_ADDR_BIT_A]) ?
                       `DDC_RB_B_HI : `DDC_RB_A_HI;
        else if (genActive_r && fifoBus.wrReady)
            rbIdx_r <= rbIdx_r + 3'h1;
    end

    assign fifoBus.wrValid = genActive_r;
    assign fifoBus.wrData  = rbByte;
    assign fifoBus.flush   = startCond || stopCond;

    ddc_fifo #(
        .WIDTH (8),
        .DEPTH (16)
    ) u_fifo (
        .core_clk (core_clk),
        .resetn   (resetn),
        .bus      (fifoBus)
    );

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_ADDR_ACK: assert property (
        (rxTake && byteIdx_r == `DDC_BYTE_ADDR && addrHit) |=> ackEn_r && state_r == ST_RXEND)
        else $error("own address not prepared for ack");
    AST_FOREIGN_NACK: assert property (
        (rxTake && byteIdx_r == `DDC_BYTE_ADDR && !addrHit) |=> !ackEn_r ##1 !sdaOe)
        else $error("foreign address acked");
    AST_EXTRA_BYTE_NACK: assert property (
        (rxTake && byteIdx_r == `DDC_BYTE_OVER) |=> !ackEn_r)
        else $error("fourth write byte acked");
    AST_INREG_ONLY_ON_EXEC: assert property (
        !execPulse |=> $stable(inReg[0]) && $stable(inReg[1]))
        else $error("input register changed without full word");
    AST_WRITE_THROUGH: assert property (
        (execPulse && cmdCode == `DDC_CMD_WR_IN && cmdByte_r[`DDC_ADDR_BIT_A]
         && !strobeS && !mask_r[`DDC_ADDR_BIT_A]) |=> chaDacCode == $past(dataCode))
        else $error("low strobe did not pass write to dac");
    AST_DEFERRED: assert property (
        (execPulse && cmdCode == `DDC_CMD_WR_IN && strobeS) |=> $stable(dacReg[0]))
        else $error("dac changed on write with strobe high");
    AST_STROBE_LOAD: assert property (
        (strobeFall && !mask_r[`DDC_ADDR_BIT_B] && !execPulse) |=> chbDacCode == $past(inReg[1]))
        else $error("strobe fall did not load dac");
    AST_MASK_BLOCKS: assert property (
        (mask_r[`DDC_ADDR_BIT_A] && !execPulse) |=> $stable(chaDacCode))
        else $error("masked channel followed strobe");
    AST_PD_LOAD: assert property (
        (execPulse && cmdCode == `DDC_CMD_PWR) |=> {chbPdModeHi, chbPdModeLo} == $past(shift_r[7:6])
        && {chaPdModeHi, chaPdModeLo} == $past(shift_r[1:0]))
        else $error("power-down fields wrong");
    AST_PD_KEEPS_DAC: assert property (
        (execPulse && cmdCode == `DDC_CMD_PWR) |=> $stable(dacReg[0]) && $stable(dacReg[1]))
        else $error("power-down disturbed dac register");
    AST_MASK_LOAD: assert property (
        (execPulse && cmdCode == `DDC_CMD_MASK) |=> mask_r == $past(shift_r[3:0]))
        else $error("mask not loaded");
    AST_RB_START_A: assert property (
        (rxTake && !readMode_r && byteIdx_r == `DDC_BYTE_CMD && shift_r[`DDC_ADDR_BIT_A])
        |=> rbIdx_r == `DDC_RB_A_HI)
        else $error("readback did not start at channel A");
    AST_RB_WRAP: assert property (
        (genActive_r && fifoBus.wrReady && rbIdx_r == `DDC_RB_B_LO && !startCond && !stopCond
         && !rxTake) |=> rbIdx_r == `DDC_RB_A_HI && fifoBus.wrData == inReg[0][11:4])
        else $error("readback did not wrap to channel A");
    AST_NACK_ENDS: assert property (
        (state_r == ST_MACK && sclRise && sdaS && !startCond && !stopCond) |=> state_r == ST_IDLE)
        else $error("master nack did not end transmit");

    COV_WRITE_UPDATE: cover property (execPulse && cmdCode == `DDC_CMD_WR_UPD);
    COV_READ_BYTE:    cover property (txLoad && fifoBus.rdValid);
    COV_STROBE_LOAD:  cover property (strobeFall && !mask_r[`DDC_ADDR_BIT_A]);
    COV_MASK_WRITE:   cover property (execPulse && cmdCode == `DDC_CMD_MASK);
endmodule // ddc_top

// *** verif/ddc_master_model.sv ***
module ddc_master_model (
    input  wire logic core_clk,
    input  wire logic sdaLine,
    output logic      sclLine,
    output logic      sdaPull
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus: clock parked high, data left to the pull-up
    initial
    begin
        sclLine = 1'b1;
        sdaPull = 1'b0;
    end
    ////////////////////////
    // quarter of the 200 ns bus clock
    task automatic q();
        repeat (2) @(posedge core_clk);
    endtask
    // extra wait lets a slave ack drop before the clock rises
    task automatic start();
        sdaPull <= 1'b0;
        q();
        q();
        sclLine <= 1'b1;
        q();
        sdaPull <= 1'b1;
        q();
        sclLine <= 1'b0;
        q();
    endtask
    task automatic stop();
        sdaPull <= 1'b1;
        q();
        sclLine <= 1'b1;
        q();
        sdaPull <= 1'b0;
        q();
        q();
    endtask
    // data moves only while the clock is low
    task automatic bitx(input logic b, output logic r);
        sdaPull <= ~b;
        q();
        sclLine <= 1'b1;
        q();
        q();
        r = sdaLine;
        sclLine <= 1'b0;
        q();
    endtask
    // eight bits msb first, then the ninth ack clock
    task automatic xfer(input logic [7:0] d, input logic mAck,
                        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r[i]);
        bitx(mAck, ack);
    endtask
endmodule // ddc_master_model

// *** verif/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ddc_pkg::*;
    logic       core_clk    = 1'b0;
    logic       resetn      = 1'b0;
    logic       loadStrobeN = 1'b1;
    logic       sclLine;
    logic       sdaPull;
    logic       sdaOut;
    logic       sdaOe;
    logic       sdaWire;
    logic       strapHi     = 1'b0;
    ddc_code_t  chaDacCode;
    ddc_code_t  chbDacCode;
    logic [3:0] pdMode;
    int         error_cnt   = 0;
    int         checks_done = 0;
    int         cycleCnt    = 0;
    // open-drain wire with pull-up
    assign sdaWire = !sdaPull && !(sdaOe && !sdaOut);
    always #12.5 core_clk = ~core_clk;
    ddc_master_model m (
        .core_clk(core_clk),
        .sdaLine (sdaWire),
        .sclLine (sclLine),
        .sdaPull (sdaPull)
    );
    ddc_top dut (
        .core_clk      (core_clk),
        .resetn        (resetn),
        .sclIn         (sclLine),
        .sdaIn         (sdaWire),
        .sdaOut        (sdaOut),
        .sdaOe         (sdaOe),
        .busAddrStrapLo(1'b1),
        .busAddrStrapHi(strapHi),
        .loadStrobeN   (loadStrobeN),
        .chaDacCode    (chaDacCode),
        .chbDacCode    (chbDacCode),
        .chaPdModeHi   (pdMode[1]),
        .chaPdModeLo   (pdMode[0]),
        .chbPdModeHi   (pdMode[3]),
        .chbPdModeLo   (pdMode[2])
    );
    ////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // sends the first n bytes of b, first one is the address
    task automatic wr(input logic [31:0] b, input int n, input logic expAck);
        logic [7:0] r;
        logic       k;
        m.start();
        for (int i = 3; i >= 4 - n; i--)
        begin
            m.xfer(b[8*i+:8], 1'b1, r, k);
            chk(k, (i == 3) ? expAck : 1'b0);
        end
        m.stop();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic pulse();
        @(posedge core_clk) loadStrobeN <= 1'b0;
        repeat (6) @(posedge core_clk);
        loadStrobeN <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic t_load();
        wr(32'h1A31ABC0, 4, 1'b0);
        chk(chaDacCode, 12'hABC);
        wr(32'h1A181230, 4, 1'b0);
        chk(chbDacCode, 12'h000);
        pulse();
        chk(chbDacCode, 12'h123);
        @(posedge core_clk) loadStrobeN <= 1'b0;
        wr(32'h1A115550, 4, 1'b0);
        chk(chaDacCode, 12'h555);
        loadStrobeN <= 1'b1;
        wr(32'h1A184560, 4, 1'b0);
        wr(32'h1A280000, 4, 1'b0);
        chk(chbDacCode, 12'h456);
        wr(32'h1A09FFF0, 4, 1'b0);
        chk(chaDacCode, 12'h555);
    endtask
    task automatic t_pd();
        for (int k = 0; k < 4; k++)
        begin
            wr({16'h1A40, 8'h00, k[1:0], 4'hF, k[1:0]}, 4, 1'b0);
            chk(pdMode, {k[1:0], k[1:0]});
        end
        wr(32'h1A317770, 4, 1'b0);
        chk(chaDacCode, 12'h777);
    endtask
    // address nibble of the mask command is junk on purpose
    task automatic t_mask();
        wr(32'h1A5F0001, 4, 1'b0);
        wr(32'h1A192460, 4, 1'b0);
        pulse();
        chk(chaDacCode, 12'h777);
        chk(chbDacCode, 12'h246);
        wr(32'h1A500008, 4, 1'b0);
        wr(32'h1A193690, 4, 1'b0);
        pulse();
        chk(chbDacCode, 12'h246);
        chk(chaDacCode, 12'h369);
    endtask
    task automatic t_abort();
        logic [39:0] d;
        logic [7:0]  r;
        logic        k;
        d = 40'h1A31555077;
        wr(32'h1A31FFF0, 3, 1'b0);
        chk(chaDacCode, 12'h369);
        wr(32'h30310000, 1, 1'b1);
        // a fifth byte is refused, the word already taken stays
        m.start();
        for (int i = 4; i >= 0; i--)
        begin
            m.xfer(d[8*i+:8], 1'b1, r, k);
            chk(k, i == 0);
        end
        m.stop();
        chk(chaDacCode, 12'h555);
        // strap moves the bus address; old one is then foreign
        strapHi <= 1'b1;
        wr(32'h1A310010, 1, 1'b1);
        wr(32'h1E31DEF0, 4, 1'b0);
        chk(chaDacCode, 12'hDEF);
        strapHi <= 1'b0;
        wr(32'h1A31ABC0, 4, 1'b0);
        wr(32'h1A381230, 4, 1'b0);
        chk(chaDacCode, 12'hABC);
    endtask
    task automatic rd(input logic [7:0] ctrl, input int n);
        logic [7:0] exp [9];
        logic [7:0] r;
        logic       k;
        exp = '{8'hAB, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h30, 8'hAB};
        m.start();
        m.xfer(8'h1A, 1'b1, r, k);
        chk(k, 1'b0);
        m.xfer(ctrl, 1'b1, r, k);
        chk(k, 1'b0);
        m.start();
        m.xfer(8'h1B, 1'b1, r, k);
        chk(k, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            m.xfer(8'hFF, i == n - 1, r, k);
            chk(r, exp[i]);
        end
        m.stop();
    endtask
    task automatic final_report();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////
    // hang guard, far above the roughly 7700 cycles needed
    always @(posedge core_clk)
    begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == 30000)
        begin
            error_cnt++;
            final_report();
        end
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_load();
        t_pd();
        t_mask();
        t_abort();
        rd(8'h11, 9);
        rd(8'h19, 2);
        final_report();
    end
endmodule // tb_top
